//--- src/ldu_display_defs.vh
// Constants for the loop indicator display controller
`ifndef LDU_DISPLAY_DEFS_VH
`define LDU_DISPLAY_DEFS_VH
// Clock and timing, times in their own unit
`define LDU_CLK_MHZ    100
`define LDU_TICK_US    1000
`define LDU_TICK_MS    1
`define LDU_REVERT_MS  10000
`define LDU_UNCAL_MS   4000
`define LDU_CHECK_MS   1000
`define LDU_RETRY_MS   250
// Loop current in microamps
`define LDU_I_LO       2400
`define LDU_I_HI       21600
`define LDU_I_ZERO     4000
`define LDU_I_SPAN     16000
// Fixed point scale of configured values (1e-4)
`define LDU_SCALE      10000
`define LDU_INH2O_F    277066
`define LDU_F_OFS      320000
`define LDU_MAX_SHOW   19999
// Unit codes in table order
`define LDU_U_MA       4'h0
`define LDU_U_PCT      4'h1
`define LDU_U_PSI      4'h2
`define LDU_U_INH2O    4'h3
`define LDU_U_BAR      4'h4
`define LDU_U_KGCM     4'h5
`define LDU_U_DEGC     4'h6
`define LDU_U_DEGF     4'h7
`define LDU_U_CUSTOM   4'h8
`define LDU_N_UNITS    5'h09
// Message codes
`define LDU_M_NUM      3'h0
`define LDU_M_DASH4    3'h1
`define LDU_M_DASH_R   3'h2
`define LDU_M_DASH_L   3'h3
`define LDU_M_UNCAL    3'h4
`define LDU_M_FAULT    3'h5
`define LDU_M_BLANK    3'h6
`define LDU_D_BLANK    4'hf
// Register word indices (byte address = 4 * index)
`define LDU_R_CTRL     3'h0
`define LDU_R_ZERO     3'h1
`define LDU_R_FULL     3'h2
`define LDU_R_CKSUM    3'h3
`define LDU_R_STATUS   3'h4
`define LDU_CTRL_RST   32'h00000001
`define LDU_CKSUM_RST  32'h00000001
`define LDU_CAL_BIT    4
`endif

//--- src/ldu_display.v
// Run mode display, unit cycling and memory fault control of a loop indicator
`timescale 1ns/1ps
`include "ldu_display_defs.vh"
module ldu_display #(
    parameter TICK_CYC     = `LDU_TICK_US * `LDU_CLK_MHZ,
    parameter BAR_PER_PSI  = 689,
    parameter KGCM_PER_PSI = 703
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Measurement and buttons
    input  wire [15:0] loop_ua_i,
    input  wire        mode_btn_i,
    input  wire        select_btn_i,
    // Memory loader
    input  wire        nv_nack_i,
    output reg         nv_reread_o,
    // LCD
    output reg  [19:0] digits_o,
    output reg  [2:0]  dp_pos_o,
    output reg         minus_o,
    output reg  [3:0]  unit_o,
    output reg  [2:0]  msg_o
);
    localparam [31:0] TICK_FULL = TICK_CYC - 1;
    localparam [23:0] TICK_LAST = TICK_FULL[23:0];
    localparam        CK_OK     = 1'b0;
    localparam        CK_BAD    = 1'b1;
    ////////////////////////////////////////////////////////////////////////////
    function is_pres(input [3:0] u);
        is_pres = (u >= `LDU_U_PSI) && (u <= `LDU_U_KGCM);
    endfunction
    function is_temp(input [3:0] u);
        is_temp = (u == `LDU_U_DEGC) || (u == `LDU_U_DEGF);
    endfunction
    function avail(input [3:0] b, input [3:0] u);
        avail = (u == `LDU_U_MA) || (u == `LDU_U_PCT) || (u == b)
              || (is_pres(b) && is_pres(u)) || (is_temp(b) && is_temp(u));
    endfunction
    function [3:0] next_unit(input [3:0] b, input [3:0] s);
        integer k;
        reg [4:0] c;
        reg       found;
        begin
            next_unit = b;
            found = 1'b0;
            c = {1'b0, s};
            for (k = 1; k < 9; k = k + 1)
            begin
                c = c + 5'h01;
                if (c >= `LDU_N_UNITS)
                    c = 5'h00;
                if (!found && avail(b, c[3:0]))
                begin
                    next_unit = c[3:0];
                    found = 1'b1;
                end
            end
        end
    endfunction
    // Pressure goes through psi; offsets apply to values, not to spans
    function signed [47:0] conv(input signed [47:0] v, input [3:0] b, input [3:0] u,
                                input off);
        reg signed [47:0] p;
        begin
            conv = v;
            p = v;
            if (b != u && is_pres(b) && is_pres(u))
            begin
                case (b)
                    `LDU_U_INH2O: p = v * `LDU_SCALE / `LDU_INH2O_F;
                    `LDU_U_BAR:   p = v * `LDU_SCALE / BAR_PER_PSI;
                    `LDU_U_KGCM:  p = v * `LDU_SCALE / KGCM_PER_PSI;
                    default:      p = v;
                endcase
                case (u)
                    `LDU_U_INH2O: conv = p * `LDU_INH2O_F / `LDU_SCALE;
                    `LDU_U_BAR:   conv = p * BAR_PER_PSI / `LDU_SCALE;
                    `LDU_U_KGCM:  conv = p * KGCM_PER_PSI / `LDU_SCALE;
                    default:      conv = p;
                endcase
            end
            else if (b == `LDU_U_DEGC && u == `LDU_U_DEGF)
                conv = v * 9 / 5 + (off ? `LDU_F_OFS : 0);
            else if (b == `LDU_U_DEGF && u == `LDU_U_DEGC)
                conv = (v - (off ? `LDU_F_OFS : 0)) * 5 / 9;
        end
    endfunction
    // 0..4 decimals, 5 means whole tens
    function [2:0] dec_sel(input signed [47:0] s);
        reg signed [47:0] a;
        begin
            a = (s < 0) ? -s : s;
            if (a >= 100000000)    dec_sel = 3'h5;
            else if (a >= 10000000) dec_sel = 3'h0;
            else if (a >= 1000000)  dec_sel = 3'h1;
            else if (a >= 100000)   dec_sel = 3'h2;
            else if (a >= 10000)    dec_sel = 3'h3;
            else                    dec_sel = 3'h4;
        end
    endfunction
    function signed [47:0] divisor(input [2:0] sel);
        case (sel)
            3'h0:    divisor = 10000;
            3'h1:    divisor = 1000;
            3'h2:    divisor = 100;
            3'h3:    divisor = 10;
            3'h4:    divisor = 1;
            default: divisor = 100000;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    reg [31:0] ctrl;
    reg [31:0] zero_val;
    reg [31:0] full_val;
    reg [31:0] cksum;
    reg        mode_s1;
    reg        mode_s2;
    reg        mode_d;
    reg [23:0] tick_cnt;
    reg        tick;
    reg        alt_on;
    reg [3:0]  alt_unit;
    reg [13:0] revert_cnt;
    reg [11:0] uncal_cnt;
    reg        uncal_ph;
    reg [9:0]  ck_cnt;
    reg        ck_state;
    reg        blink;
    reg        halted;
    wire [3:0] base   = ctrl[3:0];
    wire [3:0] shown  = alt_on ? alt_unit : base;
    wire       press  = mode_s2 & ~mode_d & ~halted;
    wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Writes land at the edge where the master sees ack, its request still standing
    wire       wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & ~halted;
    wire [2:0] widx   = wb_adr_i[4:2];
    wire       ck_ok  = (ctrl + zero_val + full_val) == cksum;
    function [31:0] bmerge(input [31:0] o, input [31:0] n, input [3:0] s);
        integer b;
        begin
            bmerge = o;
            for (b = 0; b < 4; b = b + 1)
                if (s[b])
                    bmerge[b*8 +: 8] = n[b*8 +: 8];
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Register file; these words are the RAM copy of the nonvolatile data
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl     <= `LDU_CTRL_RST;
            zero_val <= 32'h00000000;
            full_val <= 32'h00000000;
            cksum    <= `LDU_CKSUM_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_wr)
            begin
                case (widx)
                    `LDU_R_CTRL:  ctrl     <= bmerge(ctrl, wb_dat_i, wb_sel_i);
                    `LDU_R_ZERO:  zero_val <= bmerge(zero_val, wb_dat_i, wb_sel_i);
                    `LDU_R_FULL:  full_val <= bmerge(full_val, wb_dat_i, wb_sel_i);
                    `LDU_R_CKSUM: cksum    <= bmerge(cksum, wb_dat_i, wb_sel_i);
                    default:      ;
                endcase
            end
            if (wb_req && !wb_we_i)
            begin
                case (widx)
                    `LDU_R_CTRL:   wb_dat_o <= ctrl;
                    `LDU_R_ZERO:   wb_dat_o <= zero_val;
                    `LDU_R_FULL:   wb_dat_o <= full_val;
                    `LDU_R_CKSUM:  wb_dat_o <= cksum;
                    `LDU_R_STATUS: wb_dat_o <= {22'h000000, halted, ck_state, msg_o, 1'b0, shown};
                    default:       wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Button sync, millisecond tick, unit cycling and fault supervision
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_s1     <= 1'b0;
            mode_s2     <= 1'b0;
            mode_d      <= 1'b0;
            tick_cnt    <= 24'h000000;
            tick        <= 1'b0;
            alt_on      <= 1'b0;
            alt_unit    <= `LDU_U_MA;
            revert_cnt  <= 14'h0000;
            uncal_cnt   <= 12'h000;
            uncal_ph    <= 1'b0;
            ck_cnt      <= 10'h000;
            ck_state    <= CK_OK;
            blink       <= 1'b0;
            halted      <= 1'b0;
            nv_reread_o <= 1'b0;
        end
        else
        begin
            mode_s1     <= mode_btn_i;
            mode_s2     <= mode_s1;
            mode_d      <= mode_s2;
            nv_reread_o <= 1'b0;
            tick        <= (tick_cnt == TICK_LAST);
            tick_cnt    <= (tick_cnt == TICK_LAST) ? 24'h000000 : tick_cnt + 24'h000001;
            if (nv_nack_i)
                halted <= 1'b1;
            if (press)
            begin
                alt_unit   <= next_unit(base, shown);
                alt_on     <= (next_unit(base, shown) != base);
                revert_cnt <= 14'h0000;
            end
            else if (wb_wr && widx == `LDU_R_CTRL)
                alt_on <= 1'b0;
            else if (tick && alt_on)
            begin
                revert_cnt <= revert_cnt + 14'h0001;
                if (revert_cnt == `LDU_REVERT_MS / `LDU_TICK_MS - 1)
                    alt_on <= 1'b0;
            end
            if (tick)
            begin
                uncal_cnt <= uncal_cnt + 12'h001;
                if (uncal_cnt == `LDU_UNCAL_MS / `LDU_TICK_MS - 1)
                begin
                    uncal_cnt <= 12'h000;
                    uncal_ph  <= ~uncal_ph;
                end
            end
            if (tick && !halted)
            begin
                ck_cnt <= ck_cnt + 10'h001;
                case (ck_state)
                    CK_OK:
                        if (ck_cnt == `LDU_CHECK_MS / `LDU_TICK_MS - 1)
                        begin
                            ck_cnt <= 10'h000;
                            if (!ck_ok)
                            begin
                                nv_reread_o <= 1'b1;
                                ck_state    <= CK_BAD;
                                blink       <= 1'b1;
                            end
                        end
                    CK_BAD:
                        if (ck_cnt == `LDU_RETRY_MS / `LDU_TICK_MS - 1)
                        begin
                            ck_cnt <= 10'h000;
                            if (ck_ok)
                                ck_state <= CK_OK;
                            else
                            begin
                                nv_reread_o <= 1'b1;
                                blink       <= ~blink;
                            end
                        end
                    default: ck_state <= CK_OK;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Conversion and display formatting
    reg signed [47:0] cur;
    reg signed [47:0] d_ma;
    reg signed [47:0] zs;
    reg signed [47:0] fs;
    reg signed [47:0] base_v;
    reg signed [47:0] val;
    reg signed [47:0] cnt;
    reg        [2:0]  sel;
    reg        [2:0]  next_dp;
    reg        [2:0]  next_msg;
    reg        [19:0] next_digits;
    reg               next_minus;
    reg        [3:0]  dg;
    reg signed [47:0] dig_q;
    reg               lead;
    integer           i;
    always @*
    begin
        cur    = {32'h00000000, loop_ua_i};
        d_ma   = cur - `LDU_I_ZERO;
        zs     = {{16{zero_val[31]}}, zero_val};
        fs     = {{16{full_val[31]}}, full_val};
        base_v = zs + d_ma * (fs - zs) / `LDU_I_SPAN;
        if (shown == `LDU_U_MA)
        begin
            val = cur * 10;
            sel = 3'h3;
        end
        else if (shown == `LDU_U_PCT)
        begin
            val = d_ma * 125 / 2;
            sel = 3'h2;
        end
        else
        begin
            val = conv(base_v, base, shown, 1'b1);
            sel = dec_sel(conv(fs - zs, base, shown, 1'b0));
        end
        cnt = val / divisor(sel);
        if (sel == 3'h5)
            cnt = cnt * 10;
        next_dp    = (sel == 3'h5) ? 3'h0 : sel;
        next_minus = (cnt < 0);
        if (cnt < 0)
            cnt = -cnt;
        if (halted)
            next_msg = `LDU_M_FAULT;
        else if (ck_state == CK_BAD)
            next_msg = blink ? `LDU_M_FAULT : `LDU_M_BLANK;
        else if (!ctrl[`LDU_CAL_BIT] && uncal_ph)
            next_msg = `LDU_M_UNCAL;
        else if (cur > `LDU_I_HI)
            next_msg = `LDU_M_DASH_R;
        else if (cur < `LDU_I_LO)
            next_msg = `LDU_M_DASH_L;
        else if (cnt > `LDU_MAX_SHOW)
            next_msg = `LDU_M_DASH4;
        else
            next_msg = `LDU_M_NUM;
        next_digits = {5{`LDU_D_BLANK}};
        lead = 1'b1;
        for (i = 4; i >= 0; i = i - 1)
        begin
            dig_q = cnt / divisor(3'h4 - i[2:0]) % 10;
            dg    = dig_q[3:0];
            if (lead && dg == 4'h0 && i > next_dp)
                next_digits[i*4 +: 4] = `LDU_D_BLANK;
            else
            begin
                lead = 1'b0;
                next_digits[i*4 +: 4] = dg;
            end
        end
        if (next_msg != `LDU_M_NUM)
        begin
            next_digits = {5{`LDU_D_BLANK}};
            next_minus  = 1'b0;
        end
    end
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            digits_o <= {5{`LDU_D_BLANK}};
            dp_pos_o <= 3'h0;
            minus_o  <= 1'b0;
            unit_o   <= `LDU_U_PCT;
            msg_o    <= `LDU_M_BLANK;
        end
        else
        begin
            digits_o <= next_digits;
            dp_pos_o <= next_dp;
            minus_o  <= next_minus;
            unit_o   <= shown;
            msg_o    <= next_msg;
        end
    end
endmodule // ldu_display

//--- sim/ldu_display_properties.sv
// Concurrent checks on the ports of the loop indicator display block
`timescale 1ns/1ps
`include "ldu_display_defs.vh"
module ldu_chk #(
    parameter TICK_CYC = 2
) (
    // Clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // Bus
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // Measurement, memory and display
    input wire [15:0] loop_ua_i,
    input wire        nv_nack_i,
    input wire        nv_reread_o,
    input wire [2:0]  dp_pos_o,
    input wire [2:0]  msg_o
);
localparam int GAP_MIN = 250 * TICK_CYC - 1;
reg [15:0] gap;
reg        seen;
reg [1:0]  halt_q;
////////////////////////////////////////
// Gap saturates so a long quiet spell never wraps into a false short gap
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        gap    <= 16'h0000;
        seen   <= 1'b0;
        halt_q <= 2'h0;
    end
    else
    begin
        gap    <= nv_reread_o ? 16'h0000 : gap + {15'h0000, ~&gap};
        seen   <= seen | nv_reread_o;
        halt_q <= {halt_q[0], halt_q[0] | nv_nack_i};
    end
end
////////////////////////////////////////
default clocking cb @(posedge clk_i);
endclocking
default disable iff (rst_i);
chk_ack_reply: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");
chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside ack");
chk_hi_dashes: assert property (
    msg_o == `LDU_M_DASH_R |-> $past(loop_ua_i) > `LDU_I_HI)
    else $error("right dashes without overcurrent");
chk_lo_dashes: assert property (
    msg_o == `LDU_M_DASH_L |-> $past(loop_ua_i) < `LDU_I_LO)
    else $error("left dashes without undercurrent");
chk_num_band: assert property (
    msg_o == `LDU_M_NUM |-> $past(loop_ua_i) >= `LDU_I_LO && $past(loop_ua_i) <= `LDU_I_HI)
    else $error("number shown outside the valid current band");
chk_dash4_band: assert property (
    msg_o == `LDU_M_DASH4 |-> $past(loop_ua_i) >= `LDU_I_LO && $past(loop_ua_i) <= `LDU_I_HI)
    else $error("four dashes outside the valid current band");
chk_dp_range: assert property (dp_pos_o <= 3'h4)
    else $error("decimal count above four");
chk_reread_gap: assert property (nv_reread_o && seen |-> gap >= GAP_MIN)
    else $error("reread requests closer than the retry interval");
chk_fault_steady: assert property (halt_q[1] |-> msg_o == `LDU_M_FAULT)
    else $error("halt not shown as a steady fault");
cov_reread: cover property (nv_reread_o);
cov_dash_r: cover property (msg_o == `LDU_M_DASH_R);
cov_uncal: cover property (msg_o == `LDU_M_UNCAL);
endmodule // ldu_chk
bind ldu_display ldu_chk #(.TICK_CYC(TICK_CYC)) u_ldu_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .loop_ua_i(loop_ua_i),
    .nv_nack_i(nv_nack_i), .nv_reread_o(nv_reread_o), .dp_pos_o(dp_pos_o), .msg_o(msg_o));

//--- sim/ldu_panel.sv
// Push buttons and configuration memory at the far side of the display block
`timescale 1ns/1ps
module ldu_panel (
    // Clock
    input  wire clk_i,
    // Memory loader
    input  wire nv_reread_i,
    output reg  nv_nack_o,
    // Buttons
    output reg  mode_btn_o,
    output reg  select_btn_o
);
integer reread_cnt;
initial
begin
    nv_nack_o    = 1'b0;
    mode_btn_o   = 1'b0;
    select_btn_o = 1'b0;
    reread_cnt   = 0;
end
////////////////////////////////////////
// Counting reloads lets the bench judge the retry pacing
always @(posedge clk_i)
    if (nv_reread_i)
        reread_cnt <= reread_cnt + 1;
// Held for several clocks since the pin crosses a two stage synchroniser
task press(input integer which);
    begin
        @(posedge clk_i);
        if (which == 0)
            mode_btn_o <= 1'b1;
        else
            select_btn_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        mode_btn_o   <= 1'b0;
        select_btn_o <= 1'b0;
        repeat (6) @(posedge clk_i);
    end
endtask
// A write that the memory never acknowledges
task fail_write;
    begin
        @(posedge clk_i);
        nv_nack_o <= 1'b1;
        @(posedge clk_i);
        nv_nack_o <= 1'b0;
    end
endtask
endmodule // ldu_panel

//--- sim/tb.sv
// Self-checking bench for the loop indicator display block
`timescale 1ns/1ps
`include "ldu_display_defs.vh"
module tb;
localparam tick = 2;
localparam [31:0] full = 32'h000f4240;
reg         clk_i = 1'b0;
reg         rst_i = 1'b1;
reg         cyc = 1'b0;
reg         stb = 1'b0;
reg         we = 1'b0;
reg  [7:0]  adr = 8'h00;
reg  [31:0] wdat = 32'h00000000;
reg  [15:0] loop_ua = 16'h2ee0;
reg  [31:0] q;
wire [31:0] rdat;
wire        ack, nack, reread, mode_btn, sel_btn, minus;
wire [19:0] digits;
wire [2:0]  dp, msg;
wire [3:0]  unit;
integer     err_count = 0;
integer     cmp_count = 0;
integer     ticks = 0;
integer     i, a, b, s;
ldu_display #(.TICK_CYC(tick)) u_ldu_display (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .loop_ua_i(loop_ua), .mode_btn_i(mode_btn), .select_btn_i(sel_btn),
    .nv_nack_i(nack), .nv_reread_o(reread), .digits_o(digits), .dp_pos_o(dp),
    .minus_o(minus), .unit_o(unit), .msg_o(msg));
ldu_panel u_ldu_panel (.clk_i(clk_i), .nv_reread_i(reread), .nv_nack_o(nack),
    .mode_btn_o(mode_btn), .select_btn_o(sel_btn));
initial
    forever #5 clk_i = ~clk_i;
// Longest path is about 44000 cycles
always @(posedge clk_i)
begin
    ticks = ticks + 1;
    if (ticks == 90000)
    begin
        err_count = err_count + 1;
        report_and_stop;
    end
end
////////////////////////////////////////
task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("MISMATCH %0s expected %h seen %h", name, exp, seen);
        end
    end
endtask
task wb(input w, input [7:0] ad, input [31:0] d);
    begin
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= ad;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    end
endtask
task cfg(input [31:0] c, input [31:0] f);
    begin
        wb(1'b1, 8'h00, c);
        wb(1'b1, 8'h04, 32'h0);
        wb(1'b1, 8'h08, f);
        wb(1'b1, 8'h0c, c + f);
        // A periodic check may catch the words half written; wait until it settles
        wb(1'b0, 8'h10, 32'h0);
        while (q[8] === 1'b1)
            wb(1'b0, 8'h10, 32'h0);
        repeat (4) @(posedge clk_i);
    end
endtask
task show(input [15:0] ua);
    begin
        @(posedge clk_i);
        loop_ua <= ua;
        repeat (4) @(posedge clk_i);
    end
endtask
task steps(input [31:0] c, input integer n, input [23:0] sq);
    begin
        cfg(c, full);
        check("base", unit, c[3:0]);
        for (i = 0; i < n; i = i + 1)
        begin
            u_ldu_panel.press(0);
            check("step", unit, sq[4*i +: 4]);
        end
    end
endtask
////////////////////////////////////////
task t_regs;
    begin
        wb(1'b0, 8'h00, 32'h0);
        check("ctrl", q, `LDU_CTRL_RST);
        wb(1'b0, 8'h14, 32'h0);
        check("unmapped", q, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        check("status", q, 32'h00000001);
    end
endtask
task t_scale;
    begin
        cfg(32'h12, full);
        show(16'h2ee0);
        check("num", {msg, dp, digits}, {`LDU_M_NUM, 3'h1, 20'hff500});
        show(16'h0fa0);
        check("zero", {minus, digits}, {1'b0, 20'hfff00});
        u_ldu_panel.press(1);
        check("select", unit, `LDU_U_PSI);
        show(16'h2ee0);
        u_ldu_panel.press(0);
        check("inh2o", {unit, dp, digits}, {`LDU_U_INH2O, 3'h0, 20'hf1385});
    end
endtask
task t_range;
    begin
        cfg(32'h12, full);
        show(16'h54c4);
        check("over", msg, `LDU_M_DASH_R);
        show(16'h5460);
        check("top", msg, `LDU_M_NUM);
        show(16'h08fc);
        check("under", msg, `LDU_M_DASH_L);
        show(16'h0960);
        check("bottom", {msg, minus}, {`LDU_M_NUM, 1'b1});
        cfg(32'h12, 32'h0beb9af0);
        show(16'h4e84);
        check("wide", msg, `LDU_M_DASH4);
        show(16'h4e20);
        check("fits", msg, `LDU_M_NUM);
    end
endtask
task t_revert;
    begin
        u_ldu_panel.press(0);
        repeat (9900 * tick) @(posedge clk_i);
        check("hold", unit, `LDU_U_INH2O);
        repeat (200 * tick) @(posedge clk_i);
        check("revert", unit, `LDU_U_PSI);
    end
endtask
// Eight samples a second apart always see exactly half in each phase
task t_uncal;
    begin
        cfg(32'h02, full);
        show(16'h2ee0);
        a = 0;
        b = 0;
        repeat (8)
        begin
            repeat (1000 * tick) @(posedge clk_i);
            a = a + (msg === `LDU_M_UNCAL);
            b = b + (msg === `LDU_M_NUM);
        end
        check("uncal", a, 4);
        check("reading", b, 4);
        cfg(32'h12, full);
    end
endtask
task t_cksum;
    begin
        wb(1'b1, 8'h0c, 32'h0);
        s = u_ldu_panel.reread_cnt;
        i = 0;
        while (u_ldu_panel.reread_cnt == s && i < 1100 * tick)
        begin
            @(posedge clk_i);
            i = i + 1;
        end
        check("first", u_ldu_panel.reread_cnt - s, 1);
        s = u_ldu_panel.reread_cnt;
        a = 0;
        b = 0;
        repeat (950 * tick)
        begin
            @(posedge clk_i);
            a = a + (msg === `LDU_M_FAULT);
            b = b + (msg === `LDU_M_BLANK);
        end
        check("retry", u_ldu_panel.reread_cnt - s, 3);
        check("blink", (a > 0) && (b > 0), 1);
        wb(1'b1, 8'h0c, 32'h12 + full);
        repeat (600 * tick) @(posedge clk_i);
        check("healed", msg, `LDU_M_NUM);
    end
endtask
task t_halt;
    begin
        u_ldu_panel.fail_write;
        repeat (3) @(posedge clk_i);
        a = 0;
        repeat (1000 * tick)
        begin
            @(posedge clk_i);
            a = a + (msg !== `LDU_M_FAULT);
        end
        check("steady", a, 0);
        wb(1'b1, 8'h00, 32'h11);
        wb(1'b0, 8'h00, 32'h0);
        check("locked", q, 32'h12);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("cleared", msg, `LDU_M_NUM);
    end
endtask
task report_and_stop;
    begin
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
endtask
initial
begin
    repeat (4) @(posedge clk_i);
    check("rst_msg", msg, `LDU_M_BLANK);
    check("rst_unit", unit, `LDU_U_PCT);
    rst_i <= 1'b0;
    t_regs;
    t_scale;
    t_range;
    steps(32'h10, 2, 24'h000001);
    steps(32'h18, 3, 24'h000810);
    steps(32'h16, 4, 24'h006107);
    steps(32'h17, 4, 24'h007610);
    steps(32'h13, 6, 24'h321054);
    steps(32'h12, 6, 24'h210543);
    t_revert;
    t_uncal;
    t_cksum;
    t_halt;
    report_and_stop;
end
endmodule // tb
